// *** pkg/crank_pkg.sv ***
// Shared constants and types of the crank contact monitor
`default_nettype none
package crank_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ               = 40_000_000;
    localparam int MS_PER_S             = 1000;
    localparam int MS_TICK_CYCLES       = CLK_HZ / MS_PER_S;
    localparam int RESTART_MIN_SHORT_MS = 100;
    localparam int RESTART_MIN_LONG_MS  = 350;
    localparam int RESTART_MAX_S        = 30;
    localparam int RESTART_MAX_MS       = RESTART_MAX_S * MS_PER_S;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  CTRL_OFFS     = 8'h00;
    localparam logic [7:0]  STATUS_OFFS   = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFFS = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFFS = 8'h0C;
    localparam logic [3:0]  CTRL_RESET    = 4'h2;
    localparam logic [2:0]  IRQ_RESET     = 3'h0;

    // Interrupt bit positions
    localparam int IRQ_CONTACT = 0;
    localparam int IRQ_RAMP    = 1;
    localparam int IRQ_CLEARED = 2;

    // Pin positions inside the synchroniser vector
    localparam int PIN_TOP     = 0;
    localparam int PIN_UP      = 1;
    localparam int PIN_ADV     = 2;
    localparam int PIN_RESTART = 3;
    localparam int PIN_N       = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic errflag_en;
        logic min_long;
        logic restart_en;
        logic advance_en;
    } cfg_t;

    typedef struct packed {
        logic error_flag;
        logic rampdown_error;
        logic contact_error;
        logic restart_pending;
        logic startup_area;
        logic top_area;
        logic release_ok;
    } out_t;

    typedef enum logic [2:0] {
        PH_INIT,
        PH_TOP,
        PH_DOWN,
        PH_STARTUP,
        PH_ADVANCED,
        PH_TOPAREA,
        PH_HALT
    } phase_t;

endpackage
`default_nettype wire

// *** logic/restart_pulse_qualifier.sv ***
// Qualifies the restart pulse by its high time
`timescale 1ns/1ps
`default_nettype none
module restart_pulse_qualifier
    import crank_pkg::*;
#(
    parameter int TICK_CYCLES  = MS_TICK_CYCLES,
    parameter int MIN_SHORT_MS = RESTART_MIN_SHORT_MS,
    parameter int MIN_LONG_MS  = RESTART_MIN_LONG_MS,
    parameter int MAX_MS       = RESTART_MAX_MS
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Pulse in
    input  wire logic min_long,
    input  wire logic level,
    input  wire logic fall,
    // Result
    output logic      valid
);

    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam int MS_W  = $clog2(MAX_MS + 2);

    logic [DIV_W-1:0] div_q;
    logic [MS_W-1:0]  ms_q;
    logic             tick;
    logic [MS_W-1:0]  min_ms;
    logic             in_range;

    // ------------------------------------------------------------
    // Millisecond divider, held at zero while low so timing is exact
    // ------------------------------------------------------------
    assign tick     = level && (div_q == DIV_W'(TICK_CYCLES - 1));
    assign min_ms   = min_long ? MS_W'(MIN_LONG_MS) : MS_W'(MIN_SHORT_MS);
    assign in_range = (ms_q >= min_ms) && (ms_q <= MS_W'(MAX_MS));

    always_ff @(posedge clk)
    begin
        if (!rst_b || !level || tick)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end

    // Saturates one past the maximum so overlong pulses stay refused
    always_ff @(posedge clk)
    begin
        if (!rst_b || (!level && !fall))
            ms_q <= '0;
        else if (tick && ms_q <= MS_W'(MAX_MS))
            ms_q <= ms_q + MS_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            valid <= 1'b0;
        else
            valid <= fall && in_range;
    end

    property p_valid_min;
        @(posedge clk) disable iff (!rst_b)
        valid |-> $past(ms_q) >= $past(min_ms) && $past(ms_q) <= MS_W'(MAX_MS);
    endproperty
    a_valid_min: assert property (p_valid_min) else $error("restart pulse out of range");

endmodule // restart_pulse_qualifier
`default_nettype wire

// *** logic/crank_contact_monitor.sv ***
// Crank contact monitor for a single-direction mechanical press
//
// Operation
// - Release goes high right after start-up, whatever the contact levels.
// - Start history is checked when top contact falls with upstroke contact low.
// - Restart-pending may rise without restart input; then only stop-run clears it.
// - Resting at top with top contact high holds release and top-area high.
// - Upstroke contact rising starts upstroke and raises startup-area.
// - Top contact rising again raises top-area and drops startup-area.
// - Any out-of-order contact sequence raises contact error, drops release, pends restart.
// - Enabled advance contact falling ends startup early; otherwise it is ignored.
// - With restart enabled a low-high-low pulse within limits, or a stop-run, clears errors.
// - Minimum restart high time is selectable, 100 ms or 350 ms.
// - Optional error flag is high whenever contact or ramp error is present.
// - Top contact must rise with upstroke high and fall with upstroke low.
// - Upstroke contact must rise with top low and fall with top high.
`timescale 1ns/1ps
`default_nettype none
module crank_contact_monitor
    import crank_pkg::*;
#(
    parameter int TICK_CYCLES  = MS_TICK_CYCLES,
    parameter int MIN_SHORT_MS = RESTART_MIN_SHORT_MS,
    parameter int MIN_LONG_MS  = RESTART_MIN_LONG_MS,
    parameter int MAX_MS       = RESTART_MAX_MS
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Press contacts, asynchronous pins
    input  wire logic              top_position_switch,
    input  wire logic              upstroke_position_switch,
    input  wire logic              advance_switch,
    input  wire logic              restart_button,
    // Drive control, same clock
    input  wire logic              drive_start,
    input  wire logic              ctrl_run,
    // Monitor outputs
    output logic                   release_ok,
    output logic                   top_area,
    output logic                   startup_area,
    output logic                   restart_pending,
    output logic                   contact_error,
    output logic                   rampdown_error,
    output logic                   error_flag,
    // Interrupt
    output logic                   irq
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] offs);
        hit = (a == offs);
    endfunction

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1_q;
    logic [PIN_N-1:0] sync2_q;
    logic [PIN_N-1:0] prev_q;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    logic             run_prev_q;
    logic             seen_q;
    cfg_t             cfg_q;
    logic [2:0]       irq_stat_q;
    logic [2:0]       irq_mask_q;
    phase_t           phase_q;
    phase_t           phase_d;
    phase_t           level_phase;
    out_t             status;
    logic             top;
    logic             up;
    logic             run_rise;
    logic             active;
    logic             contact_fault;
    logic             ramp_fault;
    logic             advance_end;
    logic             restart_valid;
    logic             err_clear;
    logic             contact_d;
    logic             ramp_d;
    logic             pend_d;
    logic             err_any_d;
    logic [2:0]       irq_evt;
    logic [2:0]       irq_stat_d;
    logic             wr_ctrl;
    logic             wr_stat;
    logic             wr_mask;
    logic [31:0]      rd_mux;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    assign pin_raw = {restart_button, advance_switch, upstroke_position_switch,
                      top_position_switch};

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise     = sync2_q & ~prev_q;
    assign fall     = ~sync2_q & prev_q;
    assign top      = sync2_q[PIN_TOP];
    assign up       = sync2_q[PIN_UP];
    assign run_rise = ctrl_run && !run_prev_q;

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    assign active = ctrl_run && (phase_q != PH_INIT) && (phase_q != PH_HALT);

    // Edge pairs checked against the other contact's present level
    assign contact_fault = active && ((rise[PIN_TOP] && !up)
                                   || (fall[PIN_TOP] && up)
                                   || (rise[PIN_UP] && top)
                                   || (fall[PIN_UP] && !top));

    // Leaving top without a high start since the top phase began
    assign ramp_fault = active && (phase_q == PH_TOP) && fall[PIN_TOP] && !up
                        && !seen_q;

    assign advance_end = cfg_q.advance_en && fall[PIN_ADV]
                         && (phase_q == PH_STARTUP);

    // Without the restart option only a stop-run transition clears
    assign err_clear = run_rise || (cfg_q.restart_en && restart_valid);

    // Set wins over clear
    assign contact_d = contact_fault || (contact_error && !err_clear);
    assign ramp_d    = ramp_fault || (rampdown_error && !err_clear);
    assign pend_d    = contact_fault || ramp_fault
                       || (restart_pending && !err_clear);
    assign err_any_d = contact_d || ramp_d;

    restart_pulse_qualifier #(
        .TICK_CYCLES  (TICK_CYCLES),
        .MIN_SHORT_MS (MIN_SHORT_MS),
        .MIN_LONG_MS  (MIN_LONG_MS),
        .MAX_MS       (MAX_MS)
    ) u_restart (
        .clk      (clk),
        .rst_b    (rst_b),
        .min_long (cfg_q.min_long),
        .level    (sync2_q[PIN_RESTART]),
        .fall     (fall[PIN_RESTART]),
        .valid    (restart_valid)
    );

    // ------------------------------------------------------------
    // Phase tracking
    // ------------------------------------------------------------
    always_comb
    begin
        case ({top, up})
            2'b10:   level_phase = PH_TOP;
            2'b00:   level_phase = PH_DOWN;
            2'b01:   level_phase = PH_STARTUP;
            default: level_phase = PH_TOPAREA;
        endcase
    end

    always_comb
    begin
        phase_d = phase_q;
        case (phase_q)
            PH_INIT:
                phase_d = err_any_d ? PH_HALT : level_phase;
            PH_TOP:
                if (fall[PIN_TOP] && !up)
                    phase_d = PH_DOWN;
            PH_DOWN:
                if (rise[PIN_UP] && !top)
                    phase_d = PH_STARTUP;
            PH_STARTUP:
                if (rise[PIN_TOP] && up)
                    phase_d = PH_TOPAREA;
                else if (advance_end)
                    phase_d = PH_ADVANCED;
            PH_ADVANCED:
                if (rise[PIN_TOP] && up)
                    phase_d = PH_TOPAREA;
            PH_TOPAREA:
                if (fall[PIN_UP] && top)
                    phase_d = PH_TOP;
            default:
                if (!err_any_d)
                    phase_d = PH_INIT;
        endcase
        if (contact_fault || ramp_fault)
            phase_d = PH_HALT;
        if (!ctrl_run)
            phase_d = PH_INIT;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            phase_q    <= PH_INIT;
            run_prev_q <= 1'b0;
            seen_q     <= 1'b0;
        end
        else
        begin
            phase_q    <= phase_d;
            run_prev_q <= ctrl_run;
            seen_q     <= (phase_q == PH_TOP) ? (seen_q || drive_start) : drive_start;
        end
    end

    // ------------------------------------------------------------
    // Output registers, one cycle behind the phase decision
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            release_ok      <= 1'b0;
            top_area        <= 1'b0;
            startup_area    <= 1'b0;
            restart_pending <= 1'b0;
            contact_error   <= 1'b0;
            rampdown_error  <= 1'b0;
            error_flag      <= 1'b0;
        end
        else
        begin
            release_ok      <= !err_any_d && phase_d != PH_INIT && phase_d != PH_HALT;
            top_area        <= phase_d == PH_TOP || phase_d == PH_ADVANCED
                               || phase_d == PH_TOPAREA;
            startup_area    <= phase_d == PH_STARTUP;
            restart_pending <= pend_d;
            contact_error   <= contact_d;
            rampdown_error  <= ramp_d;
            error_flag      <= cfg_q.errflag_en && err_any_d;
        end
    end

    // ------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr && hit(reg_addr, CTRL_OFFS);
    assign wr_stat = reg_wr && hit(reg_addr, IRQ_STAT_OFFS);
    assign wr_mask = reg_wr && hit(reg_addr, IRQ_MASK_OFFS);

    assign irq_evt[IRQ_CONTACT] = contact_fault;
    assign irq_evt[IRQ_RAMP]    = ramp_fault;
    assign irq_evt[IRQ_CLEARED] = err_clear && restart_pending;

    // Write one to clear; a new event in the same cycle keeps its bit
    assign irq_stat_d = (irq_stat_q & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | irq_evt;

    assign status = {error_flag, rampdown_error, contact_error, restart_pending,
                     startup_area, top_area, release_ok};

    always_comb
    begin
        if (hit(reg_addr, CTRL_OFFS))
            rd_mux = 32'(cfg_q);
        else if (hit(reg_addr, STATUS_OFFS))
            rd_mux = 32'({phase_q, 1'b0, status});
        else if (hit(reg_addr, IRQ_STAT_OFFS))
            rd_mux = 32'(irq_stat_q);
        else if (hit(reg_addr, IRQ_MASK_OFFS))
            rd_mux = 32'(irq_mask_q);
        else
            rd_mux = 32'h0000_0000;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cfg_q      <= CTRL_RESET;
            irq_stat_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
            irq        <= 1'b0;
            reg_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl)
                cfg_q <= reg_wdata[3:0];
            if (wr_mask)
                irq_mask_q <= reg_wdata[2:0];
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_d & (wr_mask ? reg_wdata[2:0] : irq_mask_q));
            reg_rdata  <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_release_start;
        @(posedge clk) disable iff (!rst_b)
        run_rise |=> release_ok && !contact_error && !rampdown_error;
    endproperty
    a_release_start: assert property (p_release_start) else $error("release not high after start");

    property p_ramp_error;
        @(posedge clk) disable iff (!rst_b)
        ramp_fault |=> rampdown_error && !release_ok && restart_pending;
    endproperty
    a_ramp_error: assert property (p_ramp_error) else $error("ramp-down error not raised");

    property p_no_restart_input;
        @(posedge clk) disable iff (!rst_b)
        !cfg_q.restart_en && restart_pending && ctrl_run && run_prev_q |=> restart_pending;
    endproperty
    a_no_restart_input: assert property (p_no_restart_input) else $error("pending cleared wrongly");

    property p_top_rest;
        @(posedge clk) disable iff (!rst_b)
        phase_q == PH_TOP && !contact_error && !rampdown_error |-> release_ok && top_area;
    endproperty
    a_top_rest: assert property (p_top_rest) else $error("top rest outputs wrong");

    property p_top_order;
        @(posedge clk) disable iff (!rst_b)
        active && rise[PIN_TOP] && !up |=> contact_error ##1 contact_error;
    endproperty
    a_top_order: assert property (p_top_order) else $error("top contact order not flagged");

    property p_up_order;
        @(posedge clk) disable iff (!rst_b)
        active && rise[PIN_UP] && top |=> contact_error && !release_ok && restart_pending;
    endproperty
    a_up_order: assert property (p_up_order) else $error("upstroke order not flagged");

    property p_startup;
        @(posedge clk) disable iff (!rst_b)
        ctrl_run && phase_q == PH_DOWN && rise[PIN_UP] && !top && !contact_fault
        |=> startup_area && !top_area;
    endproperty
    a_startup: assert property (p_startup) else $error("startup area not raised");

    property p_top_again;
        @(posedge clk) disable iff (!rst_b)
        ctrl_run && phase_q == PH_STARTUP && rise[PIN_TOP] && up && !contact_fault
        |=> top_area && !startup_area;
    endproperty
    a_top_again: assert property (p_top_again) else $error("top area not raised");

    property p_advance;
        @(posedge clk) disable iff (!rst_b)
        ctrl_run && advance_end && !contact_fault && !rise[PIN_TOP] |=> top_area && !startup_area;
    endproperty
    a_advance: assert property (p_advance) else $error("advance did not end startup");

    property p_restart_clear;
        @(posedge clk) disable iff (!rst_b)
        cfg_q.restart_en && restart_valid && !contact_fault && !ramp_fault
        |=> !contact_error && !rampdown_error && !restart_pending && !error_flag;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart did not clear");

    property p_error_flag;
        @(posedge clk) disable iff (!rst_b)
        $stable(cfg_q) |-> error_flag == (cfg_q.errflag_en && (contact_error || rampdown_error));
    endproperty
    a_error_flag: assert property (p_error_flag) else $error("error flag mismatch");

endmodule // crank_contact_monitor
`default_nettype wire

// *** dv/press_contacts_model.sv ***
// Press contacts and drive start seen by the monitor
`timescale 1ns/1ps
`default_nettype none
module press_contacts_model
(
    // Clock
    input  wire logic clk,
    // Contacts and drive start
    output var logic  top_sw,
    output var logic  up_sw,
    output var logic  adv_sw,
    output var logic  restart_sw,
    output var logic  drive_start
);
    // Every mandatory contact is driven from time zero
    initial
    begin
        {top_sw, up_sw, adv_sw, restart_sw, drive_start} = 5'h14;
    end
    task automatic set_pins(input logic t, input logic u, input logic a);
        @(posedge clk);
        {top_sw, up_sw, adv_sw} <= {t, u, a};
    endtask
    // Start stays high or goes high then low before top falls
    task automatic set_start(input logic s);
        @(posedge clk);
        drive_start <= s;
    endtask
    // Clean low-high-low pulse; no bounce, so length is exact
    task automatic press_restart(input int cycles);
        @(posedge clk);
        restart_sw <= 1'b1;
        repeat (cycles) @(posedge clk);
        restart_sw <= 1'b0;
    endtask
endmodule // press_contacts_model
`default_nettype wire

// *** dv/tb_crank_contact_monitor.sv ***
// Self-checking bench of the crank contact monitor
`timescale 1ns/1ps
`default_nettype none
module tb_crank_contact_monitor import crank_pkg::*;;
    // ------------------------------------------------------------
    // Short ms tick keeps the 60 ms pulse cheap
    // ------------------------------------------------------------
    localparam int TICK = 10;
    localparam int MIN_S = 3;
    localparam int MIN_L = 6;
    localparam int MAXM = 50;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ctrl_run = 1'b0;
    logic        top_sw, up_sw, adv_sw, restart_sw, drive_start, irq;
    out_t        o;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    logic [31:0] rnd = 32'h0000_e299;
    int          dur_q[$] = '{2, 60, 4, 4};
    bit          long_q[$] = '{0, 0, 1, 0};
    bit          ok;

    always #12.5 clk = ~clk;

    press_contacts_model pm_u (.clk(clk), .top_sw(top_sw), .up_sw(up_sw), .adv_sw(adv_sw),
        .restart_sw(restart_sw), .drive_start(drive_start));
    crank_contact_monitor #(.TICK_CYCLES(TICK), .MIN_SHORT_MS(MIN_S), .MIN_LONG_MS(MIN_L),
        .MAX_MS(MAXM)) dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .top_position_switch(top_sw), .upstroke_position_switch(up_sw),
        .advance_switch(adv_sw), .restart_button(restart_sw), .drive_start(drive_start),
        .ctrl_run(ctrl_run), .release_ok(o.release_ok), .top_area(o.top_area),
        .startup_area(o.startup_area), .restart_pending(o.restart_pending),
        .contact_error(o.contact_error), .rampdown_error(o.rampdown_error),
        .error_flag(o.error_flag), .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    // Pins need three cycles through the synchroniser; eight leaves margin
    task automatic settle(input logic [6:0] e, input logic [6:0] m);
        repeat (8) @(posedge clk);
        #1;
        check({25'h0, o & m}, {25'h0, e & m});
    endtask
    task automatic step(input logic t, u, a, input logic [6:0] e, input logic [6:0] m);
        pm_u.set_pins(t, u, a);
        settle(e, m);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(CTRL_OFFS, 32'h0000_0002);
        rd_chk(IRQ_MASK_OFFS, 32'h0000_0000);
        rnd = xs(rnd);
        wr(8'h10, rnd);
        rd_chk(8'h10, 32'h0000_0000);
        wr(CTRL_OFFS, 32'h0000_000B);
        rd_chk(CTRL_OFFS, 32'h0000_000B);
        wr(IRQ_MASK_OFFS, 32'h0000_0007);
        @(posedge clk);
        ctrl_run <= 1'b1;
        settle(7'h03, 7'h7F);
        rd_chk(STATUS_OFFS, 32'h0000_0103);
        step(0, 0, 1, 7'h68, 7'h79);
        check({31'h0, irq}, 32'h0000_0001);
        rd_chk(IRQ_STAT_OFFS, 32'h0000_0002);
        wr(IRQ_STAT_OFFS, 32'h0000_0002);
        rd_chk(IRQ_STAT_OFFS, 32'h0000_0000);
        while (dur_q.size() > 0)
        begin
            wr(CTRL_OFFS, long_q[0] ? 32'h0000_000F : 32'h0000_000B);
            pm_u.press_restart(dur_q[0] * TICK);
            ok = dur_q[0] >= (long_q[0] ? MIN_L : MIN_S) && dur_q[0] <= MAXM;
            settle(ok ? 7'h01 : 7'h68, 7'h79);
            void'(dur_q.pop_front());
            void'(long_q.pop_front());
        end
        rd_chk(IRQ_STAT_OFFS, 32'h0000_0004);
        wr(IRQ_STAT_OFFS, 32'h0000_0004);
        pm_u.set_start(1'b1);
        step(0, 1, 1, 7'h05, 7'h7F);
        step(1, 1, 1, 7'h03, 7'h7F);
        step(1, 0, 1, 7'h03, 7'h7F);
        pm_u.set_start(1'b0);
        step(0, 0, 1, 7'h01, 7'h7F);
        step(0, 1, 1, 7'h05, 7'h7F);
        step(0, 1, 0, 7'h03, 7'h7F);
        step(1, 1, 0, 7'h03, 7'h7F);
        step(1, 0, 0, 7'h03, 7'h7F);
        step(1, 0, 1, 7'h03, 7'h7F);
        // Restart input off: only a stop-run cycle may clear the fault
        wr(CTRL_OFFS, 32'h0000_0009);
        wr(IRQ_MASK_OFFS, 32'h0000_0000);
        step(1, 1, 1, 7'h58, 7'h79);
        check({31'h0, irq}, 32'h0000_0000);
        rd_chk(IRQ_STAT_OFFS, 32'h0000_0001);
        pm_u.press_restart(4 * TICK);
        settle(7'h58, 7'h79);
        @(posedge clk);
        ctrl_run <= 1'b0;
        repeat (4) @(posedge clk);
        ctrl_run <= 1'b1;
        settle(7'h03, 7'h7F);
        step(0, 1, 1, 7'h58, 7'h79);
        // Top rising while upstroke is low must be refused as well
        @(posedge clk);
        ctrl_run <= 1'b0;
        @(posedge clk);
        ctrl_run <= 1'b1;
        settle(7'h05, 7'h7F);
        step(1, 0, 1, 7'h58, 7'h79);
        give_verdict();
    end
endmodule // tb_crank_contact_monitor
`default_nettype wire
